// File: core/eag_angle_gen.sv
// encoder angle generator top: counter, angle scaling, override, avalon registers
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "eag_params.svh"
// Summary of operation
// - counter at wrap limit returns to zero
// - index pulse loads the index load value
// - count valid only after preload or index
// - angle is 12-bit unsigned full turn
// - angle is scale times count over 4096
// - encoder angle feeds both dq transforms
// - override enable selects host angle for angle_voltage only, resets zero
// - 32-bit position count, host writable, resets zero
// - six hall preset registers reset to zero
// - separate enables gate index load and counting
module eag_angle_gen
    import eag_pkg::*;
#(
    parameter int CNT_W = `EAG_CNT_W
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic        enc_index,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic      [11:0] angle_forward,
    output logic      [11:0] angle_inverse,
    output logic      [11:0] angle_voltage,
    output logic             angle_valid
);
    eag_evt_s   evt;
    eag_enc_s   enc_in;
    eag_bus_e   bus_st;
    eag_bus_e   next_bus_st;
    logic [2:0]       ctrl;
    logic [2:0]       next_ctrl;
    logic [CNT_W-1:0] wrap_limit;
    logic [CNT_W-1:0] next_wrap_limit;
    logic [CNT_W-1:0] index_value;
    logic [CNT_W-1:0] next_index_value;
    logic [15:0]      scale;
    logic [15:0]      next_scale;
    logic [11:0]      host_angle;
    logic [11:0]      next_host_angle;
    logic [CNT_W-1:0] hall_preset [`EAG_HALL_NUM];
    logic [CNT_W-1:0] next_hall_preset [`EAG_HALL_NUM];
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic [31:0]      wide;
    logic [31:0]      next_wide;
    logic             valid;
    logic             next_valid;
    logic [11:0]      enc_angle;
    logic [11:0]      next_enc_angle;
    logic [31:0]      rdata;
    logic [31:0]      next_rdata;
    logic             wr_take;
    logic [CNT_W+15:0] product;

    assign enc_in = '{pha: enc_a, phb: enc_b, idx: enc_index};

    // edge and index decode
    eag_quad_decoder u_dec (
        .clk  (clk),
        .srst (srst),
        .enc  (enc_in),
        .evt  (evt)
    );

    // bus handshake: one wait cycle, then ack; hold cycle lets master drop request
    always_comb begin
        case (bus_st)
            EAG_BUS_IDLE: next_bus_st = (avs_read | avs_write) ? EAG_BUS_ACK : EAG_BUS_IDLE;
            EAG_BUS_ACK:  next_bus_st = EAG_BUS_HOLD;
            EAG_BUS_HOLD: next_bus_st = EAG_BUS_IDLE;
            default:      next_bus_st = EAG_BUS_IDLE;
        endcase
    end
    assign wr_take = avs_write & (bus_st == EAG_BUS_ACK);

    // software registers
    always_comb begin
        next_ctrl        = ctrl;
        next_wrap_limit  = wrap_limit;
        next_index_value = index_value;
        next_scale       = scale;
        next_host_angle  = host_angle;
        for (int i = 0; i < `EAG_HALL_NUM; i++)
            next_hall_preset[i] = hall_preset[i];
        if (wr_take) begin
            case (avs_address)
                `EAG_OFS_CTRL:     next_ctrl        = avs_writedata[2:0];
                `EAG_OFS_WRAP:     next_wrap_limit  = avs_writedata[CNT_W-1:0];
                `EAG_OFS_INDEX:    next_index_value = avs_writedata[CNT_W-1:0];
                `EAG_OFS_SCALE:    next_scale       = avs_writedata[15:0];
                `EAG_OFS_HOST_ANG: next_host_angle  = avs_writedata[11:0];
                default: begin
                    if (avs_address >= `EAG_OFS_HALL_BASE && avs_address <= `EAG_OFS_HALL_LAST)
                        next_hall_preset[3'(avs_address - `EAG_OFS_HALL_BASE)] =
                            avs_writedata[CNT_W-1:0];
                end
            endcase
        end
    end

    // encoder counter, wide position, validity
    always_comb begin
        next_count = count;
        next_wide  = wide;
        next_valid = valid;
        if (ctrl[`EAG_CTRL_CNT_EN] && evt.up) begin
            next_count = (count == wrap_limit) ? '0 : count + 1'b1;
            next_wide  = wide + 32'h1;
        end else if (ctrl[`EAG_CTRL_CNT_EN] && evt.dn) begin
            next_count = (count == '0) ? wrap_limit : count - 1'b1;
            next_wide  = wide - 32'h1;
        end
        if (ctrl[`EAG_CTRL_IDX_EN] && evt.idx_rise) begin
            next_count = index_value;
            next_valid = 1'b1;
        end
        if (wr_take && avs_address == `EAG_OFS_PRELOAD) begin
            next_count = avs_writedata[CNT_W-1:0];
            next_valid = 1'b1;
        end
        if (wr_take && avs_address == `EAG_OFS_WIDE)
            next_wide = avs_writedata;
    end

    // single scaled multiply, modulo a full electrical turn
    assign product = count * scale;
    assign next_enc_angle = product[`EAG_ANGLE_SHIFT +: `EAG_ANGLE_W];

    // read mux
    always_comb begin
        next_rdata = `EAG_ZERO32;
        if (avs_read && bus_st == EAG_BUS_IDLE) begin
            case (avs_address)
                `EAG_OFS_CTRL:    next_rdata = {29'h0, ctrl};
                `EAG_OFS_WRAP:    next_rdata = 32'(wrap_limit);
                `EAG_OFS_INDEX:   next_rdata = 32'(index_value);
                `EAG_OFS_PRELOAD: next_rdata = 32'(count);
                `EAG_OFS_SCALE:   next_rdata = {16'h0, scale};
                `EAG_OFS_WIDE:    next_rdata = wide;
                `EAG_OFS_STATUS:  next_rdata = {31'h0, valid};
                `EAG_OFS_ANGLE:   next_rdata = {20'h0, enc_angle};
                default: begin
                    if (avs_address >= `EAG_OFS_HALL_BASE && avs_address <= `EAG_OFS_HALL_LAST)
                        next_rdata = 32'(hall_preset[3'(avs_address - `EAG_OFS_HALL_BASE)]);
                end
            endcase
        end else if (bus_st != EAG_BUS_IDLE) begin
            next_rdata = rdata;
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (srst) begin
            bus_st          <= EAG_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= `EAG_ZERO32;
            rdata           <= `EAG_ZERO32;
            ctrl            <= '0;
            wrap_limit      <= '0;
            index_value     <= '0;
            scale           <= '0;
            host_angle      <= '0;
            for (int i = 0; i < `EAG_HALL_NUM; i++)
                hall_preset[i] <= '0;
            count           <= '0;
            wide            <= `EAG_ZERO32;
            valid           <= 1'b0;
            enc_angle       <= '0;
            angle_forward   <= '0;
            angle_inverse   <= '0;
            angle_voltage   <= '0;
            angle_valid     <= 1'b0;
        end else begin
            bus_st          <= next_bus_st;
            avs_waitrequest <= ~(next_bus_st == EAG_BUS_ACK);
            rdata           <= next_rdata;
            avs_readdata    <= next_rdata;
            ctrl            <= next_ctrl;
            wrap_limit      <= next_wrap_limit;
            index_value     <= next_index_value;
            scale           <= next_scale;
            host_angle      <= next_host_angle;
            for (int i = 0; i < `EAG_HALL_NUM; i++)
                hall_preset[i] <= next_hall_preset[i];
            count           <= next_count;
            wide            <= next_wide;
            valid           <= next_valid;
            enc_angle       <= next_enc_angle;
            angle_forward   <= next_enc_angle;
            angle_inverse   <= next_enc_angle;
            angle_voltage   <= next_ctrl[`EAG_CTRL_HOST_ANG] ? next_host_angle
                                                             : next_enc_angle;
            angle_valid     <= next_valid;
        end
    end

    // wrap to zero on an up count at the limit
    property p_wrap;
        @(posedge clk) disable iff (srst)
        (ctrl[`EAG_CTRL_CNT_EN] && evt.up && count == wrap_limit
         && !(ctrl[`EAG_CTRL_IDX_EN] && evt.idx_rise)
         && !(wr_take && avs_address == `EAG_OFS_PRELOAD)) |=> (count == '0);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap to zero");

    // index load
    property p_index;
        @(posedge clk) disable iff (srst)
        (ctrl[`EAG_CTRL_IDX_EN] && evt.idx_rise && !(wr_take && avs_address == `EAG_OFS_PRELOAD))
            |=> (count == $past(index_value) && valid);
    endproperty
    a_index: assert property (p_index) else $error("index load missed");

    // no counting while disabled
    property p_gate;
        @(posedge clk) disable iff (srst)
        (!ctrl[`EAG_CTRL_CNT_EN] && !(ctrl[`EAG_CTRL_IDX_EN] && evt.idx_rise) && !wr_take)
            |=> $stable(count);
    endproperty
    a_gate: assert property (p_gate) else $error("count moved while disabled");

    // angle follows scaled count one cycle later
    property p_angle;
        @(posedge clk) disable iff (srst)
        1'b1 |=> (angle_forward == `EAG_ANGLE_W'($past(32'(count) * 32'(scale)) >> `EAG_ANGLE_SHIFT)
                  && angle_inverse == angle_forward);
    endproperty
    a_angle: assert property (p_angle) else $error("angle not scaled count");

    // override selects host angle
    property p_override;
        @(posedge clk) disable iff (srst)
        ctrl[`EAG_CTRL_HOST_ANG] |=> (angle_voltage == $past(host_angle) || $past(wr_take));
    endproperty
    a_override: assert property (p_override) else $error("override angle wrong");

    // validity stays low until preload or index
    property p_valid;
        @(posedge clk) disable iff (srst)
        (!valid && !(ctrl[`EAG_CTRL_IDX_EN] && evt.idx_rise)
         && !(wr_take && avs_address == `EAG_OFS_PRELOAD)) |=> !valid;
    endproperty
    a_valid: assert property (p_valid) else $error("valid rose without cause");

    // wide count write lands
    property p_wide;
        @(posedge clk) disable iff (srst)
        (wr_take && avs_address == `EAG_OFS_WIDE) |=> (wide == $past(avs_writedata));
    endproperty
    a_wide: assert property (p_wide) else $error("wide count write lost");

    // one edge of a phase gives one count
    property p_edge;
        @(posedge clk) disable iff (srst)
        (enc_a != $past(enc_a) && enc_b == $past(enc_b)) |=> (evt.up ^ evt.dn);
    endproperty
    a_edge: assert property (p_edge) else $error("edge not counted");

    // hall preset 0 holds after reset until written
    property p_hall;
        @(posedge clk) disable iff (srst)
        !wr_take |=> (hall_preset[0] == $past(hall_preset[0]));
    endproperty
    a_hall: assert property (p_hall) else $error("hall preset changed");

    // an up count below the limit adds exactly one
    property p_up;
        @(posedge clk) disable iff (srst)
        (ctrl[`EAG_CTRL_CNT_EN] && evt.up && count != wrap_limit && !evt.idx_rise
         && !(wr_take && avs_address == `EAG_OFS_PRELOAD)) |=> (count == $past(count) + 1'b1);
    endproperty
    a_up: assert property (p_up) else $error("up count wrong");

    // a down count above zero takes exactly one away
    property p_dn;
        @(posedge clk) disable iff (srst)
        (ctrl[`EAG_CTRL_CNT_EN] && evt.dn && count != '0 && !evt.idx_rise
         && !(wr_take && avs_address == `EAG_OFS_PRELOAD)) |=> (count == $past(count) - 1'b1);
    endproperty
    a_dn: assert property (p_dn) else $error("down count wrong");

    // a write to the first hall preset lands in it
    property p_hall_wr;
        @(posedge clk) disable iff (srst)
        (wr_take && avs_address == `EAG_OFS_HALL_BASE)
            |=> (hall_preset[0] == $past(avs_writedata[CNT_W-1:0]));
    endproperty
    a_hall_wr: assert property (p_hall_wr) else $error("hall preset write lost");
endmodule // eag_angle_gen

// File: core/eag_params.svh
// constants for the encoder angle generator: register offsets, widths, reset values
`ifndef EAG_PARAMS_SVH
`define EAG_PARAMS_SVH
`define EAG_OFS_CTRL      4'h0
`define EAG_OFS_WRAP      4'h1
`define EAG_OFS_INDEX     4'h2
`define EAG_OFS_PRELOAD   4'h3
`define EAG_OFS_SCALE     4'h4
`define EAG_OFS_HOST_ANG  4'h5
`define EAG_OFS_WIDE      4'h6
`define EAG_OFS_STATUS    4'h7
`define EAG_OFS_HALL_BASE 4'h8
`define EAG_OFS_HALL_LAST 4'hd
`define EAG_OFS_ANGLE     4'he
`define EAG_CTRL_CNT_EN   0
`define EAG_CTRL_IDX_EN   1
`define EAG_CTRL_HOST_ANG 2
`define EAG_ANGLE_W       12
`define EAG_ANGLE_SHIFT   12
`define EAG_CNT_W         16
`define EAG_ZERO32        32'h0000_0000
`define EAG_HALL_NUM      6
`endif

// File: core/eag_pkg.sv
// types shared by the encoder angle generator files
package eag_pkg;
    typedef struct packed {
        logic pha;
        logic phb;
        logic idx;
    } eag_enc_s;
    typedef enum logic [2:0] {
        EAG_BUS_IDLE = 3'b001,
        EAG_BUS_ACK  = 3'b010,
        EAG_BUS_HOLD = 3'b100
    } eag_bus_e;
    typedef struct packed {
        logic up;
        logic dn;
        logic idx_rise;
    } eag_evt_s;
endpackage

// File: core/eag_quad_decoder.sv
// quadrature edge decoder: four counts per line and index rising edge
`timescale 1ns/1ps
`include "eag_params.svh"
module eag_quad_decoder
    import eag_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     srst,
    input  wire eag_enc_s enc,
    output eag_evt_s      evt
);
    eag_enc_s prev;
    eag_evt_s next_evt;

    // direction from which phase leads; an edge of one phase counts, both phases changing at once does not
    always_comb begin
        next_evt = '0;
        if ((enc.pha ^ prev.pha) ^ (enc.phb ^ prev.phb)) begin
            if (enc.pha ^ prev.phb)
                next_evt.up = 1'b1;
            else
                next_evt.dn = 1'b1;
        end
        next_evt.idx_rise = enc.idx & ~prev.idx;
    end

    // register previous inputs and decoded events
    always_ff @(posedge clk) begin
        if (srst) begin
            prev <= enc; // track the pins so release gives no false edge
            evt  <= '0;
        end else begin
            prev <= enc;
            evt  <= next_evt;
        end
    end
endmodule // eag_quad_decoder

// File: tb/eag_encoder_model.sv
// quadrature encoder with index pulse, stepped by the bench
`timescale 1ns/1ps
module eag_encoder_model (
    input  wire logic clk,
    output logic      enc_a,
    output logic      enc_b,
    output logic      enc_index
);
    logic [1:0] phase = 2'h0;
    // gray sequence 00,10,11,01: phase a leads when stepping forward
    assign enc_a = phase[1] ^ phase[0];
    assign enc_b = phase[1];
    initial enc_index = 1'b0;
    // one call moves n edges, each held a few cycles so the decoder sees it
    task automatic step(input logic fwd, input int n);
        repeat (n) begin
            @(posedge clk);
            phase <= fwd ? phase + 2'h1 : phase - 2'h1;
            repeat (3) @(posedge clk);
        end
    endtask
    // index pulse lasting three cycles
    task automatic index_pulse();
        @(posedge clk);
        enc_index <= 1'b1;
        repeat (3) @(posedge clk);
        enc_index <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
endmodule // eag_encoder_model

// File: tb/testbench.sv
// testbench for the encoder angle generator
`timescale 1ns/1ps
module testbench;
    import eag_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        enc_a, enc_b, enc_index;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata, q;
    logic        avs_waitrequest, angle_valid;
    logic [11:0] angle_forward, angle_inverse, angle_voltage;
    int          bad_count = 0;
    int          compares = 0;
    int          cycles = 0;
    localparam logic [15:0] SCALE = 16'h1234;
    initial forever #10 clk = ~clk;
    eag_encoder_model enc (.clk(clk), .enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index));
    eag_angle_gen uut (
        .clk(clk), .srst(srst), .enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .angle_forward(angle_forward),
        .angle_inverse(angle_inverse), .angle_voltage(angle_voltage),
        .angle_valid(angle_valid)
    );
    // verdict and end of run
    task automatic wrap_up();
        if (bad_count == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // compare one value
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input string what, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, exp, q);
    endtask
    // expected encoder angle: scale times count over 4096, modulo 4096
    function automatic logic [11:0] ang(input logic [15:0] c);
        logic [31:0] p;
        p = SCALE * c;
        return p[23:12];
    endfunction
    // all three angle outputs after the pipeline has settled
    task automatic chk_ang(input logic [15:0] c, input logic [11:0] v);
        repeat (5) @(posedge clk);
        chk("angle_forward", 32'(ang(c)), 32'(angle_forward));
        chk("angle_inverse", 32'(ang(c)), 32'(angle_inverse));
        chk("angle_voltage", 32'(v), 32'(angle_voltage));
    endtask
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            wrap_up();
        end
    end
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("valid_reset", 32'h0, 32'(angle_valid));
        chk_ang(16'h0, 12'h0);
        rd(4'h7, "status_reset", 32'h0);
        rd(4'h3, "count_reset", 32'h0);
        rd(4'h6, "wide_reset", 32'h0);
        rd(4'h8, "hall_reset", 32'h0);
        rd(4'hf, "unmapped", 32'h0);
        bus(1'b1, 4'h1, 32'h7);
        bus(1'b1, 4'h4, 32'(SCALE));
        enc.step(1'b1, 4);
        rd(4'h3, "count_disabled", 32'h0);
        bus(1'b1, 4'h0, 32'h1);
        enc.step(1'b1, 5);
        rd(4'h3, "count_up", 32'h5);
        chk_ang(16'h5, ang(16'h5));
        enc.step(1'b1, 3);
        rd(4'h3, "count_wrap", 32'h0);
        enc.step(1'b0, 1);
        rd(4'h3, "count_down", 32'h7);
        rd(4'h6, "wide_count", 32'h7);
        chk_ang(16'h7, ang(16'h7));
        bus(1'b1, 4'h2, 32'h5);
        enc.index_pulse();
        rd(4'h3, "index_gated", 32'h7);
        rd(4'h7, "status_gated", 32'h0);
        bus(1'b1, 4'h0, 32'h3);
        enc.index_pulse();
        rd(4'h3, "index_load", 32'h5);
        rd(4'h7, "status_index", 32'h1);
        chk("valid_index", 32'h1, 32'(angle_valid));
        bus(1'b1, 4'h3, 32'h3);
        rd(4'h3, "preload", 32'h3);
        rd(4'he, "angle_reg", 32'(ang(16'h3)));
        bus(1'b1, 4'h6, 32'h89ab_cdef);
        rd(4'h6, "wide_write", 32'h89ab_cdef);
        bus(1'b1, 4'h8, 32'h155);
        rd(4'h8, "hall_write", 32'h155);
        bus(1'b1, 4'h5, 32'habc);
        bus(1'b1, 4'h0, 32'h5);
        chk_ang(16'h3, 12'habc);
        bus(1'b1, 4'h0, 32'h1);
        chk_ang(16'h3, ang(16'h3));
        // second reset in mid-run: every software register returns to zero
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("valid_after_reset", 32'h0, 32'(angle_valid));
        rd(4'h0, "ctrl_after_reset", 32'h0);
        rd(4'h6, "wide_after_reset", 32'h0);
        rd(4'h8, "hall_after_reset", 32'h0);
        wrap_up();
    end
endmodule // testbench
